// *** bench/tcep_tb.sv ***
// Self-checking testbench for the channel enable and polarity block.
`timescale 1ns/1ns
module testbench;
	typedef struct packed
	{
		logic [15:0] wdata;
		logic [3:0]  inp;
		logic [15:0] reg_exp;
		logic [3:0]  main_exp;
		logic [2:0]  comp_exp;
	} tcep_row_t;

	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [1:0]  lock_level = 2'h0;
	logic        preload = 1'b0;
	logic        commutation = 1'b0;
	logic [3:0]  ch_is_input = 4'h0;
	logic [3:0]  fi1 = 4'h0;
	logic [3:0]  fi2 = 4'h0;
	logic [15:0] rdata;
	logic [3:0]  main_oe, pl1, pl2, capture_req;
	logic [2:0]  comp_oe;
	wire  [13:0] f;
	wire  [15:0] fields = {2'h0, f};
	int          bad_count = 0;
	int          compares = 0;
	int          n;
	tcep_row_t   rows [6];
	logic [15:0] cap_w [5];
	logic [2:0]  cap_exp [5];

	tcep_ctrl i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.lock_level(lock_level), .compare_ctl_preload_enable(preload), .commutation(commutation),
		.ch_is_input(ch_is_input), .filtered_input_one(fi1), .filtered_input_two(fi2),
		.ch1_enable(f[0]), .ch1_polarity(f[1]), .ch1_comp_out_enable(f[2]), .ch1_comp_polarity(f[3]),
		.ch2_enable(f[4]), .ch2_polarity(f[5]), .ch2_comp_out_enable(f[6]), .ch2_comp_polarity(f[7]),
		.ch3_enable(f[8]), .ch3_polarity(f[9]), .ch3_comp_out_enable(f[10]), .ch3_comp_polarity(f[11]),
		.ch4_enable(f[12]), .ch4_polarity(f[13]), .main_out_enable(main_oe), .comp_out_enable(comp_oe),
		.polar_level_one(pl1), .polar_level_two(pl2), .capture_req(capture_req));

	// Free-running 125 MHz clock.
	always #4 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	// Compares a seen value with the expected one and counts both.
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One-cycle register write.
	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// One-cycle register read; the data is taken in the following cycle.
	task rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	// Drives both filtered inputs of channel one, then counts capture pulses over four cycles.
	task drive_count(input logic v, output int cnt);
		@(posedge clock);
		fi1 <= {3'h0, v};
		fi2 <= {3'h0, v};
		cnt = 0;
		repeat (4)
		begin
			@(posedge clock);
			#1;
			if (capture_req[0] === 1'b1)
				cnt++;
		end
	endtask : drive_count

	// Prints the counts and the verdict, then stops.
	task results;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog that cuts a hang short.
	initial
	begin
		#400000;
		bad_count++;
		results();
	end

	// Main sequence.
	initial
	begin
		logic [15:0] d;
		rows = '{'{16'hffff, 4'h0, 16'h3fff, 4'hf, 3'h7}, '{16'h5555, 4'hf, 16'h1555, 4'h0, 3'h0},
			'{16'h1111, 4'ha, 16'h1111, 4'h5, 3'h0}, '{16'h0444, 4'h2, 16'h0444, 4'h0, 3'h5},
			'{16'h3fff, 4'h9, 16'h3fff, 4'h6, 3'h6}, '{16'h0000, 4'h0, 16'h0000, 4'h0, 3'h0}};
		cap_w = '{16'h0001, 16'h0003, 16'h0009, 16'h000b, 16'h0000};
		cap_exp = '{3'b101, 3'b010, 3'b101, 3'b111, 3'b001};
		repeat (20) @(posedge clock);
		#1;
		check("fields", fields, 16'h0000);
		check("rdata", rdata, 16'h0000);
		@(posedge clock);
		rst <= 1'b0;
		$display("reset test done");
		// Ordinary cases: write, set the mode, read back and look at the enables.
		foreach (rows[i])
		begin
			wr_reg(8'h20, rows[i].wdata);
			ch_is_input <= rows[i].inp;
			rd_reg(8'h20, d);
			check("rdata", d, rows[i].reg_exp);
			check("fields", fields, rows[i].reg_exp);
			check("main_oe", {12'h0, main_oe}, {12'h0, rows[i].main_exp});
			check("comp_oe", {13'h0, comp_oe}, {13'h0, rows[i].comp_exp});
		end
		$display("row test done");
		// Complementary polarity is protected at lock levels 2 and 3.
		for (int lv = 0; lv < 4; lv++)
		begin
			@(posedge clock);
			lock_level <= 2'h0;
			wr_reg(8'h20, 16'h0000);
			lock_level <= lv[1:0];
			wr_reg(8'h20, 16'h0889);
			rd_reg(8'h20, d);
			check("lock_rd", d, (lv >= 2) ? 16'h0001 : 16'h0889);
		end
		@(posedge clock);
		lock_level <= 2'h0;
		wr_reg(8'h20, 16'h0000);
		$display("lock test done");
		// Edge selection on channel one in input mode.
		ch_is_input <= 4'hf;
		foreach (cap_w[i])
		begin
			wr_reg(8'h20, cap_w[i]);
			drive_count(1'b0, n);
			drive_count(1'b1, n);
			check("rise", n[15:0], {15'h0, cap_exp[i][2]});
			check("level1", {15'h0, pl1[0]}, {15'h0, cap_exp[i][0]});
			check("level2", {15'h0, pl2[0]}, {15'h0, cap_exp[i][0]});
			drive_count(1'b0, n);
			check("fall", n[15:0], {15'h0, cap_exp[i][1]});
		end
		$display("capture test done");
		// Preloaded complementary polarity waits for a commutation event.
		@(posedge clock);
		preload <= 1'b1;
		wr_reg(8'h20, 16'h0008);
		#1;
		check("comp_pol", fields, 16'h0000);
		rd_reg(8'h20, d);
		check("pre_rd", d, 16'h0000);
		@(posedge clock);
		commutation <= 1'b1;
		@(posedge clock);
		commutation <= 1'b0;
		#1;
		check("comp_pol", fields, 16'h0008);
		@(posedge clock);
		preload <= 1'b0;
		$display("preload test done");
		// Unmapped address reads zero and a write there changes nothing.
		wr_reg(8'h24, 16'hffff);
		rd_reg(8'h24, d);
		check("unmapped", d, 16'h0000);
		rd_reg(8'h20, d);
		check("rdata", d, 16'h0008);
		// Reset in mid-run clears the register.
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		#1;
		check("fields", fields, 16'h0000);
		check("rdata", rdata, 16'h0000);
		@(posedge clock);
		rst <= 1'b0;
		rd_reg(8'h20, d);
		check("rst_rd", d, 16'h0000);
		$display("unmapped and second reset test done");
		results();
	end
endmodule : testbench

// *** hw/tcep_ctrl.sv ***
// Capture/compare channel enable and polarity control for four timer channels.
`timescale 1ns/1ns
module tcep_ctrl
(
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [tcep_pkg::ADDR_W-1:0] addr,
	input  wire logic [tcep_pkg::DATA_W-1:0] wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [tcep_pkg::DATA_W-1:0] rdata,
	input  wire logic [1:0]                  lock_level,
	input  wire logic                        compare_ctl_preload_enable,
	input  wire logic                        commutation,
	input  wire logic [3:0]                  ch_is_input,
	input  wire logic [3:0]                  filtered_input_one,
	input  wire logic [3:0]                  filtered_input_two,
	output logic                             ch1_enable,
	output logic                             ch1_polarity,
	output logic                             ch1_comp_out_enable,
	output logic                             ch1_comp_polarity,
	output logic                             ch2_enable,
	output logic                             ch2_polarity,
	output logic                             ch2_comp_out_enable,
	output logic                             ch2_comp_polarity,
	output logic                             ch3_enable,
	output logic                             ch3_polarity,
	output logic                             ch3_comp_out_enable,
	output logic                             ch3_comp_polarity,
	output logic                             ch4_enable,
	output logic                             ch4_polarity,
	output logic      [3:0]                  main_out_enable,
	output logic      [2:0]                  comp_out_enable,
	output logic      [3:0]                  polar_level_one,
	output logic      [3:0]                  polar_level_two,
	output logic      [3:0]                  capture_req
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and write decode.

	logic [15:0] ccep_r;
	logic [15:0] ccep_nxt;
	logic [2:0]  comp_pre_r;
	logic [2:0]  comp_pre_nxt;
	logic [2:0]  comp_act_nxt;
	logic [2:0]  comp_act;
	logic [2:0]  comp_wdata;
	logic [15:0] rdata_nxt;
	logic        wr_hit;
	logic        rd_hit;
	logic        locked;
	logic        comp_wr_ok;
	logic [3:0]  ch_en;
	logic [3:0]  ch_pol;
	logic [3:0]  ch_comp_pol;
	logic [3:0]  edge_one;
	logic [3:0]  edge_two;

	// Address decode of the single register.
	assign wr_hit = wr && (addr == tcep_pkg::CCEP_OFS);
	assign rd_hit = rd && (addr == tcep_pkg::CCEP_OFS);

	// Complementary polarity writes are dropped under the higher lock levels.
	assign locked = (lock_level >= tcep_pkg::LOCK_PROTECT);
	assign comp_wr_ok = wr_hit && !locked;

	// Complementary polarity bits of the write, channel one in bit 0.
	assign comp_wdata = {wdata[tcep_pkg::COMP_POL_BIT + 2*tcep_pkg::CH_STRIDE],
		wdata[tcep_pkg::COMP_POL_BIT + tcep_pkg::CH_STRIDE],
		wdata[tcep_pkg::COMP_POL_BIT]};

	// Active complementary polarity bits as stored in the register.
	assign comp_act = {ccep_r[tcep_pkg::COMP_POL_BIT + 2*tcep_pkg::CH_STRIDE],
		ccep_r[tcep_pkg::COMP_POL_BIT + tcep_pkg::CH_STRIDE],
		ccep_r[tcep_pkg::COMP_POL_BIT]};

	// The preload copy always takes an allowed write.
	assign comp_pre_nxt = comp_wr_ok ? comp_wdata : comp_pre_r;

	// With preload on, the active bits follow the preload copy only on commutation.
	assign comp_act_nxt = compare_ctl_preload_enable ? (commutation ? comp_pre_nxt : comp_act)
		: (comp_wr_ok ? comp_wdata : comp_act);

	// Next register value: ordinary bits straight from a write, reserved bits held at zero.
	assign ccep_nxt = ((wr_hit ? wdata : ccep_r) & tcep_pkg::DIRECT_MASK)
		| ({4'h0, comp_act_nxt[2], 3'h0, comp_act_nxt[1], 3'h0, comp_act_nxt[0], 3'h0}
		& tcep_pkg::COMP_POL_MASK);

	// Read data for the cycle after a read strobe, zero otherwise and for other addresses.
	assign rdata_nxt = rd_hit ? (ccep_r & tcep_pkg::READ_MASK) : 16'h0000;

	// Register, preload copy and read data flops.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ccep_r <= tcep_pkg::CCEP_RST;
			comp_pre_r <= tcep_pkg::COMP_PRE_RST;
			rdata <= 16'h0000;
		end
		else
		begin
			ccep_r <= ccep_nxt;
			comp_pre_r <= comp_pre_nxt;
			rdata <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field outputs.

	// Channel one fields.
	assign ch1_enable = ccep_r[tcep_pkg::EN_BIT];
	assign ch1_polarity = ccep_r[tcep_pkg::POL_BIT];
	assign ch1_comp_out_enable = ccep_r[tcep_pkg::COMP_EN_BIT];
	assign ch1_comp_polarity = ccep_r[tcep_pkg::COMP_POL_BIT];

	// Channel two fields.
	assign ch2_enable = ccep_r[tcep_pkg::EN_BIT + tcep_pkg::CH_STRIDE];
	assign ch2_polarity = ccep_r[tcep_pkg::POL_BIT + tcep_pkg::CH_STRIDE];
	assign ch2_comp_out_enable = ccep_r[tcep_pkg::COMP_EN_BIT + tcep_pkg::CH_STRIDE];
	assign ch2_comp_polarity = ccep_r[tcep_pkg::COMP_POL_BIT + tcep_pkg::CH_STRIDE];

	// Channel three fields.
	assign ch3_enable = ccep_r[tcep_pkg::EN_BIT + 2*tcep_pkg::CH_STRIDE];
	assign ch3_polarity = ccep_r[tcep_pkg::POL_BIT + 2*tcep_pkg::CH_STRIDE];
	assign ch3_comp_out_enable = ccep_r[tcep_pkg::COMP_EN_BIT + 2*tcep_pkg::CH_STRIDE];
	assign ch3_comp_polarity = ccep_r[tcep_pkg::COMP_POL_BIT + 2*tcep_pkg::CH_STRIDE];

	// Channel four fields, with no complementary controls.
	assign ch4_enable = ccep_r[tcep_pkg::CH4_EN_BIT];
	assign ch4_polarity = ccep_r[tcep_pkg::CH4_POL_BIT];

	// Per-channel vectors; channel four has no complementary polarity.
	assign ch_en = {ch4_enable, ch3_enable, ch2_enable, ch1_enable};
	assign ch_pol = {ch4_polarity, ch3_polarity, ch2_polarity, ch1_polarity};
	assign ch_comp_pol = {1'b0, ch3_comp_polarity, ch2_comp_polarity, ch1_comp_polarity};

	// Output enables apply only to channels in output mode.
	assign main_out_enable = ch_en & ~ch_is_input;
	assign comp_out_enable = {ch3_comp_out_enable, ch2_comp_out_enable, ch1_comp_out_enable}
		& ~ch_is_input[2:0];

	////////////////////////////////////////////////////////////////////////////////
	// Input polarity and capture edge selection.

	// Both filtered inputs of a channel share that channel's polarity pair.
	generate
		for (genvar ch = 0; ch < 4; ch++)
		begin : g_ch
			tcep_edge_sel u_one
			(
				.clock     (clock),
				.rst       (rst),
				.sig_in    (filtered_input_one[ch]),
				.pol       (ch_pol[ch]),
				.comp_pol  (ch_comp_pol[ch]),
				.level_out (polar_level_one[ch]),
				.edge_out  (edge_one[ch])
			);
			tcep_edge_sel u_two
			(
				.clock     (clock),
				.rst       (rst),
				.sig_in    (filtered_input_two[ch]),
				.pol       (ch_pol[ch]),
				.comp_pol  (ch_comp_pol[ch]),
				.level_out (polar_level_two[ch]),
				.edge_out  (edge_two[ch])
			);
		end
	endgenerate

	// A capture is requested only by an input channel whose enable permits it.
	assign capture_req = edge_one & ch_en & ch_is_input;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// A register write: the write strobe with the register's address.
	sequence reg_write_s;
		wr_hit;
	endsequence

	// A commutation while preload is on.
	sequence commut_s;
		compare_ctl_preload_enable && commutation;
	endsequence

	// Reserved bits always read back as zero.
	reserved_zero_a : assert property (rd_hit |=> rdata[15:14] == 2'h0)
		else $error("Reserved register bits read as nonzero.");

	// Read data stand only in the cycle after the strobe.
	read_timing_a : assert property (rd_hit ##1 !rd_hit |=> rdata == 16'h0000)
		else $error("Read data held beyond one cycle.");

	// Locked writes with no commutation leave every complementary polarity bit unchanged.
	lock_keep_a : assert property ((reg_write_s and locked and !commutation) |=> $stable(comp_act))
		else $error("Complementary polarity changed under lock.");

	// With preload on and no commutation the active bits hold.
	preload_hold_a : assert property ((compare_ctl_preload_enable && !commutation) |=> $stable(comp_act))
		else $error("Active complementary polarity changed without commutation.");

	// Commutation loads the preload copy into the active bits.
	commut_load_a : assert property (commut_s |=> comp_act == comp_pre_r)
		else $error("Commutation did not load the preloaded polarity.");

	// Channel one fields follow a write.
	ch1_fields_a : assert property (reg_write_s |=> {ch1_comp_out_enable, ch1_polarity, ch1_enable}
		== $past(wdata[2:0]))
		else $error("Channel one fields did not take the write.");

	// Direct writes to complementary polarity when unlocked and not preloaded.
	comp_direct_a : assert property ((reg_write_s and !locked and !compare_ctl_preload_enable)
		|=> ch1_comp_polarity == $past(wdata[3]))
		else $error("Channel one complementary polarity did not take the write.");

	// Channels two and three take their bits of the write.
	ch23_fields_a : assert property (reg_write_s |=> {ch3_comp_out_enable, ch3_polarity, ch3_enable,
		ch2_comp_out_enable, ch2_polarity, ch2_enable}
		== {$past(wdata[10:8]), $past(wdata[6:4])})
		else $error("Channel two or three fields did not take the write.");

	// Channel four takes bits 12 and 13.
	ch4_fields_a : assert property (reg_write_s |=> {ch4_polarity, ch4_enable} == $past(wdata[13:12]))
		else $error("Channel four fields did not take the write.");

	// No capture request from a disabled or output channel.
	capture_gate_a : assert property (!ch1_enable || !ch_is_input[0] |-> !capture_req[0])
		else $error("Capture requested while blocked.");

	// Channel one's first filtered input rising, sampled one cycle apart.
	sequence ch1_rise_s;
		!filtered_input_one[0] ##1 filtered_input_one[0];
	endsequence

	// Channel one's first filtered input falling, sampled one cycle apart.
	sequence ch1_fall_s;
		filtered_input_one[0] ##1 !filtered_input_one[0];
	endsequence

	// An enabled output channel drives its main output.
	main_oe_on_a : assert property ((ch1_enable && !ch_is_input[0]) |-> main_out_enable[0])
		else $error("Main output not enabled for an enabled output channel.");

	// An input channel drives neither of its outputs.
	input_no_oe_a : assert property (ch_is_input[0] |-> !main_out_enable[0] && !comp_out_enable[0])
		else $error("Output enabled on an input channel.");

	// An enabled complementary output follows its enable bit.
	comp_oe_on_a : assert property ((ch1_comp_out_enable && !ch_is_input[0]) |-> comp_out_enable[0])
		else $error("Complementary output not enabled.");

	// Locked writes leave the preload copy unchanged as well.
	pre_lock_a : assert property ((reg_write_s and locked) |=> $stable(comp_pre_r))
		else $error("Preload copy changed under lock.");

	// An allowed write always reaches the preload copy.
	pre_load_a : assert property ((reg_write_s and !locked)
		|=> comp_pre_r == {$past(wdata[11]), $past(wdata[7]), $past(wdata[3])})
		else $error("Preload copy did not take the write.");

	// Channels two and three take complementary polarity directly when unlocked and not preloaded.
	ch23_comp_a : assert property ((reg_write_s and !locked and !compare_ctl_preload_enable)
		|=> {ch3_comp_polarity, ch2_comp_polarity} == {$past(wdata[11]), $past(wdata[7])})
		else $error("Channel two or three complementary polarity did not take the write.");

	// Read data carry the channel one fields as they stood at the strobe.
	ch1_read_a : assert property (rd_hit
		|=> rdata[3:0] == $past({ch1_comp_polarity, ch1_comp_out_enable, ch1_polarity, ch1_enable}))
		else $error("Read data disagree with channel one fields.");

	// The polarised level of input one follows channel one's polarity pair a cycle later.
	pol_level_a : assert property (1'b1
		|=> polar_level_one[0] == $past(filtered_input_one[0] ^ (ch1_polarity & ~ch1_comp_polarity)))
		else $error("Polarised level of input one is wrong.");

	// Input two shares channel one's polarity pair.
	pol_level_two_a : assert property (1'b1
		|=> polar_level_two[0] == $past(filtered_input_two[0] ^ (ch1_polarity & ~ch1_comp_polarity)))
		else $error("Polarised level of input two is wrong.");

	// Pair 00 turns a rising input into a capture edge.
	rise_cap_a : assert property ((ch1_rise_s ##0 (!ch1_polarity && !ch1_comp_polarity)) |=> edge_one[0])
		else $error("Rising edge not captured with pair 00.");

	// Pair 01 turns a falling input into a capture edge.
	fall_cap_a : assert property ((ch1_fall_s ##0 (ch1_polarity && !ch1_comp_polarity)) |=> edge_one[0])
		else $error("Falling edge not captured with pair 01.");

endmodule : tcep_ctrl

// *** hw/tcep_edge_sel.sv ***
// Polarity and capture edge selection for one filtered input of one channel.
`timescale 1ns/1ns
module tcep_edge_sel
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic sig_in,
	input  wire logic pol,
	input  wire logic comp_pol,
	output logic      level_out,
	output logic      edge_out
);

	logic prev_r;
	logic invert;
	logic rise;
	logic fall;
	logic edge_nxt;

	// Only the pair 01 inverts; 11 stays non-inverted and takes both edges.
	assign invert = pol & ~comp_pol;
	assign rise = sig_in & ~prev_r;
	assign fall = ~sig_in & prev_r;
	// Pair 00 and the unused pair 10 capture on rising edges.
	assign edge_nxt = (pol & comp_pol) ? (rise | fall) : (invert ? fall : rise);

	// Previous input level plus registered polarised level and edge pulse.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			prev_r <= 1'b0;
			level_out <= 1'b0;
			edge_out <= 1'b0;
		end
		else
		begin
			prev_r <= sig_in;
			level_out <= sig_in ^ invert;
			edge_out <= edge_nxt;
		end
	end

	// Both-edge setting answers any change of the input one cycle later.
	both_edges_a : assert property (@(posedge clock) disable iff (rst)
		(pol && comp_pol && (sig_in != prev_r)) |=> edge_out)
		else $error("Both-edge setting missed an input change.");

	// Pair 00 never captures a falling edge and pair 01 never a rising one.
	single_edge_a : assert property (@(posedge clock) disable iff (rst)
		(!comp_pol && (sig_in == pol) && (prev_r != pol)) |=> !edge_out)
		else $error("Single-edge setting captured the wrong edge.");

endmodule : tcep_edge_sel

// *** hw/tcep_pkg.sv ***
// Package with the register map, field positions and reset values of the channel enable and polarity block.
package tcep_pkg;

	// Register bus widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Byte offset of the channel enable and polarity register.
	localparam logic [7:0] CCEP_OFS = 8'h20;

	// Reset value of the register and of the preloaded complementary polarity bits.
	localparam logic [15:0] CCEP_RST = 16'h0000;
	localparam logic [2:0]  COMP_PRE_RST = 3'h0;

	// Bits stored straight from a write, and the complementary polarity bits.
	localparam logic [15:0] DIRECT_MASK = 16'h3777;
	localparam logic [15:0] COMP_POL_MASK = 16'h0888;
	localparam logic [15:0] READ_MASK = 16'h3fff;

	// Field positions of channel one; channels two and three sit CH_STRIDE and 2*CH_STRIDE higher.
	localparam int CH_STRIDE = 4;
	localparam int EN_BIT = 0;
	localparam int POL_BIT = 1;
	localparam int COMP_EN_BIT = 2;
	localparam int COMP_POL_BIT = 3;

	// Channel four fields.
	localparam int CH4_EN_BIT = 12;
	localparam int CH4_POL_BIT = 13;

	// Lock level from which the complementary polarity bits are write protected.
	localparam logic [1:0] LOCK_PROTECT = 2'h2;

endpackage : tcep_pkg
